/* File: tmc_cu.sv */
// Control unit end: mode selection, channel switch, sense bytes
// How it works
// - Host sets mode before first dual write
// - PE write records identification burst
// - Burst at load point selects PE
// - No burst selects NRZI when dual
// - NRZI read without dual gives error
// - Read mode held until load point
// - One mode set fixes seven-track settings
// - Single option: eight drives, PE only
// - Dual option: PE and NRZI
// - Seven-track option needs seven-track drives
// - Options mutually exclusive
// - Four units share sixteen drives
// - Communicator reaches drives of other units
// - Switched units run operations concurrently
// - Either channel, one at a time
// - Other channel waits while busy
// - Reserve holds unit until release
// - Partition limits drive to one channel
// - Twenty sense bytes with trace, identity
// - Failed unit goes offline alone
// - PE blocks bracketed by bursts
`timescale 1ns/10ps
`default_nettype none
module tmc_cu #(
   parameter int OP_CYCLES = tmc_pkg::OP_CYCLES_DEF,
   // Identity values are arbitrary
   parameter logic [23:0] CU_SERIAL = 24'h00_a5c3,
   parameter logic [15:0] DRV_SERIAL = 16'h3c5a,
   parameter logic [7:0] EC_LEVEL = 8'h01
) (
   tmc_link_if.cu lnk,
   input wire logic [1:0] cu_option,
   input wire logic communicator,
   input wire logic two_chan_sw,
   input wire logic cu_offline,
   input wire logic partition_en,
   input wire logic [tmc_pkg::NUM_DRIVES-1:0] partition_map,
   input wire logic [tmc_pkg::NUM_DRIVES-1:0] drive_local,
   input wire logic [tmc_pkg::NUM_DRIVES-1:0] drive_inuse,
   input wire logic [tmc_pkg::NUM_DRIVES-1:0] at_load_point,
   input wire logic [2*tmc_pkg::NUM_DRIVES-1:0] drive_option,
   input wire logic burst_seen,
   output logic id_burst_q,
   output logic block_burst_q,
   output logic xcu_access_q,
   output logic op_active_q,
   output logic reserved_q,
   output logic res_chan_q,
   output logic [tmc_pkg::DRV_W-1:0] op_drive_q,
   output logic [tmc_pkg::NUM_DRIVES-1:0] nrzi_mode
);
   localparam int CNT_W = $clog2(OP_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OP_CYCLES - 1);

   tmc_pkg::tmc_dstate_e state_q;
   tmc_pkg::tmc_stat_e st_d;
   logic [CNT_W-1:0] cnt_q;
   logic req_ready_q, rsp_valid_q, op_pe_q;
   tmc_pkg::tmc_stat_e rsp_status_q;
   logic [7:0] rsp_data_q, sense_d, trace_q;
   tmc_pkg::tmc_stat_e last_err_q;
   logic [tmc_pkg::MODE_W-1:0] mode_w [tmc_pkg::NUM_DRIVES];
   logic [tmc_pkg::NUM_DRIVES-1:0] lock_w;
   logic [tmc_pkg::DRV_W-1:0] d;
   logic [1:0] dopt;
   logic acc, ok, drive_op, long_op, dual_ok, auto_en, rd_fail, pe_now;

   // Option compatibility of a command on one drive
   function automatic logic opt_ok(input logic [1:0] cu,
                                   input logic [1:0] drv,
                                   input tmc_pkg::tmc_cmd_e cmd,
                                   input logic [7:0] arg);
      logic want_nrzi;
      want_nrzi = (cmd == tmc_pkg::CMD_MODE) && arg[tmc_pkg::MA_NRZI];
      case (cu)
         tmc_pkg::OPT_SINGLE: opt_ok = (drv == tmc_pkg::OPT_SINGLE) &&
                                       !want_nrzi;
         tmc_pkg::OPT_DUAL: opt_ok = (drv == tmc_pkg::OPT_DUAL) ||
                                     ((drv == tmc_pkg::OPT_SINGLE) &&
                                      !want_nrzi);
         tmc_pkg::OPT_SEVEN: opt_ok = (drv == tmc_pkg::OPT_SEVEN);
         default: opt_ok = 1'b0;
      endcase
   endfunction

   assign d = lnk.req_drive;
   assign dopt = drive_option[{d, 1'b0} +: 2];
   assign acc = lnk.req_valid && req_ready_q;
   assign drive_op = (lnk.req_cmd == tmc_pkg::CMD_MODE) ||
                     (lnk.req_cmd == tmc_pkg::CMD_WRITE) ||
                     (lnk.req_cmd == tmc_pkg::CMD_READ) ||
                     (lnk.req_cmd == tmc_pkg::CMD_REWIND);
   assign long_op = drive_op && (lnk.req_cmd != tmc_pkg::CMD_MODE);
   assign auto_en = (cu_option != tmc_pkg::OPT_SEVEN);
   assign dual_ok = (cu_option == tmc_pkg::OPT_DUAL) &&
                    (dopt == tmc_pkg::OPT_DUAL);
   // no burst and no dual path
   assign rd_fail = auto_en && at_load_point[d] && !lock_w[d] &&
                    !burst_seen && !dual_ok;
   assign pe_now = !mode_w[d][tmc_pkg::MA_NRZI];
   assign ok = acc && (st_d == tmc_pkg::ST_OK);

   always_comb begin
      st_d = tmc_pkg::ST_OK;
      if (cu_offline) begin
         st_d = tmc_pkg::ST_OFFLINE;
      end else if (lnk.req_chan && !two_chan_sw) begin
         st_d = tmc_pkg::ST_ERR;
      end else if (reserved_q && (res_chan_q != lnk.req_chan)) begin
         st_d = tmc_pkg::ST_BUSY;
      end else if (drive_op) begin
         if (partition_en && (partition_map[d] != lnk.req_chan)) begin
            st_d = tmc_pkg::ST_ERR;
         end else if (!drive_local[d] && !communicator) begin
            st_d = tmc_pkg::ST_ERR;
         end else if ((cu_option == tmc_pkg::OPT_SINGLE) &&
                      !communicator && (d >= tmc_pkg::SD_MAX_DRIVES)) begin
            st_d = tmc_pkg::ST_ERR;
         end else if (!opt_ok(cu_option, dopt, lnk.req_cmd,
                              lnk.req_arg)) begin
            st_d = tmc_pkg::ST_ERR;
         end else if (drive_inuse[d]) begin
            st_d = tmc_pkg::ST_BUSY;
         end else if ((lnk.req_cmd == tmc_pkg::CMD_READ) && rd_fail) begin
            st_d = tmc_pkg::ST_ERR;
         end
      end else if ((lnk.req_cmd == tmc_pkg::CMD_SENSE) &&
                   (lnk.req_arg >= tmc_pkg::SENSE_BYTES)) begin
         st_d = tmc_pkg::ST_ERR;
      end
   end

   // one request at a time, other waits
   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         state_q <= tmc_pkg::DS_IDLE;
         cnt_q <= '0;
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
      end else begin
         case (state_q)
            tmc_pkg::DS_IDLE: begin
               req_ready_q <= !acc;
               if (ok && long_op) begin
                  state_q <= tmc_pkg::DS_RUN;
                  cnt_q <= CNT_LAST;
               end else if (acc) begin
                  state_q <= tmc_pkg::DS_RESP;
                  rsp_valid_q <= 1'b1;
               end
            end
            tmc_pkg::DS_RUN: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_q == '0) begin
                  state_q <= tmc_pkg::DS_RESP;
                  rsp_valid_q <= 1'b1;
               end
            end
            default: begin
               if (lnk.rsp_ready) begin
                  state_q <= tmc_pkg::DS_IDLE;
                  rsp_valid_q <= 1'b0;
                  req_ready_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // claim and release by the owner
   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         reserved_q <= 1'b0;
         res_chan_q <= 1'b0;
      end else if (ok && (lnk.req_cmd == tmc_pkg::CMD_RESERVE)) begin
         reserved_q <= 1'b1;
         res_chan_q <= lnk.req_chan;
      end else if (ok && (lnk.req_cmd == tmc_pkg::CMD_RELEASE)) begin
         reserved_q <= 1'b0;
      end
   end

   // Burst and routing strobes, one cycle each
   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         id_burst_q <= 1'b0;
         block_burst_q <= 1'b0;
         xcu_access_q <= 1'b0;
         op_pe_q <= 1'b0;
      end else begin
         id_burst_q <= ok && (lnk.req_cmd == tmc_pkg::CMD_WRITE) &&
                       pe_now && at_load_point[d];
         // burst before and after a PE block
         block_burst_q <= (ok && (lnk.req_cmd == tmc_pkg::CMD_WRITE) &&
                           pe_now) ||
                          ((state_q == tmc_pkg::DS_RUN) && (cnt_q == '0) &&
                           op_pe_q);
         if (acc) begin
            op_pe_q <= ok && (lnk.req_cmd == tmc_pkg::CMD_WRITE) && pe_now;
         end
         xcu_access_q <= ok && drive_op && !drive_local[d];
      end
   end

   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         op_active_q <= 1'b0;
         op_drive_q <= '0;
      end else begin
         op_active_q <= (ok && long_op) ||
                        ((state_q == tmc_pkg::DS_RUN) && (cnt_q != '0));
         if (acc) begin
            op_drive_q <= d;
         end
      end
   end

   always_comb begin
      case (lnk.req_arg)
         tmc_pkg::SB_STAT: sense_d = {2'h0, cu_offline, reserved_q,
                                      res_chan_q, op_active_q, two_chan_sw,
                                      communicator};
         tmc_pkg::SB_ERR: sense_d = {6'h00, last_err_q};
         tmc_pkg::SB_TRACE: sense_d = trace_q;
         tmc_pkg::SB_CUSER: sense_d = CU_SERIAL[23:16];
         tmc_pkg::SB_CUSER + 8'h01: sense_d = CU_SERIAL[15:8];
         tmc_pkg::SB_CUSER + 8'h02: sense_d = CU_SERIAL[7:0];
         tmc_pkg::SB_DVSER: sense_d = DRV_SERIAL[15:8];
         tmc_pkg::SB_DVSER + 8'h01: sense_d = DRV_SERIAL[7:0];
         tmc_pkg::SB_DADDR: sense_d = {4'h0, op_drive_q};
         tmc_pkg::SB_OPT: sense_d = {partition_en, 5'h00, cu_option};
         tmc_pkg::SB_DOPT: sense_d = {6'h00, drive_option[{op_drive_q,
                                                          1'b0} +: 2]};
         tmc_pkg::SB_EC: sense_d = EC_LEVEL;
         tmc_pkg::SB_MODE: sense_d = {3'h0, lock_w[op_drive_q],
                                      mode_w[op_drive_q]};
         default: sense_d = 8'h00;
      endcase
   end

   // Trace keeps the last two commands for fault hunting
   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         trace_q <= 8'h00;
         last_err_q <= tmc_pkg::ST_OK;
         rsp_status_q <= tmc_pkg::ST_OK;
         rsp_data_q <= 8'h00;
      end else if (acc) begin
         trace_q <= {trace_q[3:0], 1'b0, lnk.req_cmd};
         last_err_q <= st_d;
         rsp_status_q <= st_d;
         if (ok && (lnk.req_cmd == tmc_pkg::CMD_SENSE)) begin
            rsp_data_q <= sense_d;
         end else begin
            rsp_data_q <= {3'h0, lock_w[d], mode_w[d]};
         end
      end
   end

   for (genvar i = 0; i < tmc_pkg::NUM_DRIVES; i++) begin : g_drv
      tmc_drive_mode u_mode (
         .aclk(lnk.aclk),
         .aresetn(lnk.aresetn),
         .set_mode(ok && (lnk.req_cmd == tmc_pkg::CMD_MODE) &&
                   (d == tmc_pkg::DRV_W'(i))),
         .mode_in(lnk.req_arg[tmc_pkg::MODE_W-1:0]),
         .rd_start(ok && (lnk.req_cmd == tmc_pkg::CMD_READ) &&
                   (d == tmc_pkg::DRV_W'(i))),
         .at_lp(at_load_point[i]),
         .auto_en(auto_en),
         .burst_seen(burst_seen),
         .dual_ok((cu_option == tmc_pkg::OPT_DUAL) &&
                  (drive_option[2*i +: 2] == tmc_pkg::OPT_DUAL)),
         .mode_q(mode_w[i]),
         .locked_q(lock_w[i])
      );
      assign nrzi_mode[i] = mode_w[i][tmc_pkg::MA_NRZI];
   end

   assign lnk.req_ready = req_ready_q;
   assign lnk.rsp_valid = rsp_valid_q;
   assign lnk.rsp_status = rsp_status_q;
   assign lnk.rsp_data = rsp_data_q;
endmodule
`default_nettype wire

/* File: tmc_pkg.sv */
// Shared constants and types of the tape mode and channel control
package tmc_pkg;
   localparam int NUM_DRIVES = 16;
   localparam int DRV_W = 4;
   localparam logic [3:0] SD_MAX_DRIVES = 4'h8;
   localparam int OP_CYCLES_DEF = 4;
   localparam logic [7:0] SENSE_BYTES = 8'h14;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0, CMD_MODE = 3'h1, CMD_WRITE = 3'h2, CMD_READ = 3'h3,
      CMD_RESERVE = 3'h4, CMD_RELEASE = 3'h5, CMD_SENSE = 3'h6,
      CMD_REWIND = 3'h7
   } tmc_cmd_e;

   typedef enum logic [1:0] {
      ST_OK = 2'h0, ST_BUSY = 2'h1, ST_ERR = 2'h2, ST_OFFLINE = 2'h3
   } tmc_stat_e;

   typedef enum logic [1:0] {
      OPT_SINGLE = 2'h0, OPT_DUAL = 2'h1, OPT_SEVEN = 2'h2
   } tmc_opt_e;

   typedef enum logic [1:0] {
      DS_IDLE = 2'h0, DS_RUN = 2'h1, DS_RESP = 2'h3
   } tmc_dstate_e;

   // Mode word carried in the argument of a mode set
   localparam int MA_NRZI = 0;
   localparam int MA_HIDEN = 1;
   localparam int MA_ODDPAR = 2;
   localparam int MA_CONV = 3;
   localparam int MODE_W = 4;
   localparam logic [3:0] MODE_RESET = 4'h0;

   // Sense byte positions
   localparam logic [7:0] SB_STAT = 8'h00;
   localparam logic [7:0] SB_ERR = 8'h01;
   localparam logic [7:0] SB_TRACE = 8'h02;
   localparam logic [7:0] SB_CUSER = 8'h04;
   localparam logic [7:0] SB_DVSER = 8'h07;
   localparam logic [7:0] SB_DADDR = 8'h09;
   localparam logic [7:0] SB_OPT = 8'h0a;
   localparam logic [7:0] SB_DOPT = 8'h0b;
   localparam logic [7:0] SB_EC = 8'h0c;
   localparam logic [7:0] SB_MODE = 8'h0d;

   // Host register map and AXI answers
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MSET = 8'h08;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* File: tmc_link_if.sv */
// Link between the channel end and the control unit end
`timescale 1ns/10ps
`default_nettype none
interface tmc_link_if (
   input wire logic aclk,
   input wire logic aresetn
);
   logic req_valid;
   logic req_ready;
   logic req_chan;
   tmc_pkg::tmc_cmd_e req_cmd;
   logic [tmc_pkg::DRV_W-1:0] req_drive;
   logic [7:0] req_arg;
   logic rsp_valid;
   logic rsp_ready;
   tmc_pkg::tmc_stat_e rsp_status;
   logic [7:0] rsp_data;

   modport cu (
      input aclk, aresetn, req_valid, req_chan, req_cmd, req_drive,
      req_arg, rsp_ready,
      output req_ready, rsp_valid, rsp_status, rsp_data
   );
   modport chan (
      input aclk, aresetn, req_ready, rsp_valid, rsp_status, rsp_data,
      output req_valid, req_chan, req_cmd, req_drive, req_arg, rsp_ready
   );
endinterface
`default_nettype wire

/* File: tmc_drive_mode.sv */
// Recording mode holder of one tape drive
`timescale 1ns/10ps
`default_nettype none
module tmc_drive_mode (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set_mode,
   input wire logic [tmc_pkg::MODE_W-1:0] mode_in,
   input wire logic rd_start,
   input wire logic at_lp,
   input wire logic auto_en,
   input wire logic burst_seen,
   input wire logic dual_ok,
   output logic [tmc_pkg::MODE_W-1:0] mode_q,
   output logic locked_q
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= tmc_pkg::MODE_RESET;
      end else if (rd_start && at_lp && auto_en && !locked_q) begin
         if (burst_seen) begin
            mode_q <= tmc_pkg::MODE_RESET;
         end else if (dual_ok) begin
            mode_q <= 4'h1 << tmc_pkg::MA_NRZI;
         end
      end else if (set_mode && !locked_q) begin
         mode_q <= mode_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked_q <= 1'b0;
      // hold read mode until load point
      end else if (rd_start && at_lp && auto_en) begin
         locked_q <= burst_seen || dual_ok;
      end else if (at_lp && !rd_start) begin
         locked_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: tmc_chan.sv */
// Channel end: AXI4-Lite registers driving the control unit link
`timescale 1ns/10ps
`default_nettype none
module tmc_chan (
   tmc_link_if.chan lnk,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic aw_got_q, w_got_q, pend_q, refused_q, nomode_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [15:0] cmd_q, mset_q;
   logic [1:0] st_q;
   logic [7:0] data_q;
   logic commit, wr_cmd, launch, done;

   assign commit = aw_got_q && w_got_q && !s_axi_bvalid;
   assign wr_cmd = commit && (aw_addr_q == tmc_pkg::REG_CMD);
   assign launch = wr_cmd && !pend_q &&
                   !((w_data_q[3:1] == tmc_pkg::CMD_WRITE) &&
                     !mset_q[w_data_q[7:4]]);
   assign done = lnk.rsp_valid && lnk.rsp_ready;

   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tmc_pkg::AXI_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
         end
         s_axi_awready <= !aw_got_q && !s_axi_bvalid &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_got_q && !s_axi_bvalid &&
                         !(s_axi_wvalid && s_axi_wready);
         if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ((aw_addr_q == tmc_pkg::REG_CMD) ||
                            (aw_addr_q == tmc_pkg::REG_STAT) ||
                            (aw_addr_q == tmc_pkg::REG_MSET)) ?
                           tmc_pkg::AXI_OKAY : tmc_pkg::AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end
      end
   end

   // request held until the unit takes it
   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         lnk.req_valid <= 1'b0;
         lnk.req_chan <= 1'b0;
         lnk.req_cmd <= tmc_pkg::CMD_NOP;
         lnk.req_drive <= '0;
         lnk.req_arg <= 8'h00;
         lnk.rsp_ready <= 1'b0;
         pend_q <= 1'b0;
         cmd_q <= 16'h0000;
      end else begin
         if (launch) begin
            lnk.req_valid <= 1'b1;
            lnk.req_chan <= w_data_q[0];
            lnk.req_cmd <= tmc_pkg::tmc_cmd_e'(w_data_q[3:1]);
            lnk.req_drive <= w_data_q[7:4];
            lnk.req_arg <= w_data_q[15:8];
            cmd_q <= w_data_q[15:0];
            pend_q <= 1'b1;
         end else if (lnk.req_valid && lnk.req_ready) begin
            lnk.req_valid <= 1'b0;
            lnk.rsp_ready <= 1'b1;
         end else if (done) begin
            lnk.rsp_ready <= 1'b0;
            pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         st_q <= tmc_pkg::ST_OK;
         data_q <= 8'h00;
         mset_q <= 16'h0000;
         refused_q <= 1'b0;
         nomode_q <= 1'b0;
      end else begin
         if (done) begin
            st_q <= lnk.rsp_status;
            data_q <= lnk.rsp_data;
            if ((lnk.rsp_status == tmc_pkg::ST_OK) &&
                (lnk.req_cmd == tmc_pkg::CMD_MODE)) begin
               mset_q[lnk.req_drive] <= 1'b1;
            end
         end
         if (wr_cmd) begin
            refused_q <= pend_q;
            nomode_q <= !pend_q && !launch;
         end
      end
   end

   // Reads answer one cycle after the address is taken
   always_ff @(posedge lnk.aclk) begin
      if (!lnk.aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= tmc_pkg::AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid &&
                          !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tmc_pkg::AXI_OKAY;
            if (s_axi_araddr == tmc_pkg::REG_CMD) begin
               s_axi_rdata <= {16'h0000, cmd_q};
            end else if (s_axi_araddr == tmc_pkg::REG_STAT) begin
               s_axi_rdata <= {16'h0000, data_q, 3'h0, nomode_q,
                               refused_q, st_q, pend_q};
            end else if (s_axi_araddr == tmc_pkg::REG_MSET) begin
               s_axi_rdata <= {16'h0000, mset_q};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= tmc_pkg::AXI_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tmc_link_checker.sv */
// Link handshake and answer timing checker
`timescale 1ns/10ps
`default_nettype none
module tmc_link_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire tmc_pkg::tmc_cmd_e req_cmd,
   input wire logic [7:0] req_arg,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire tmc_pkg::tmc_stat_e rsp_status
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic acc = req_valid && req_ready;
   wire logic ok = rsp_status == tmc_pkg::ST_OK;
   req_hold_a: assert property (req_valid && !req_ready |=>
      req_valid && $stable(req_cmd)) else $error("request dropped");
   take_a: assert property (acc |=> !req_ready)
      else $error("ready after take");
   one_a: assert property (rsp_valid |-> !req_ready)
      else $error("take during answer");
   rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_status)) else $error("answer dropped");
   free_a: assert property (rsp_valid && rsp_ready |=>
      !rsp_valid && req_ready) else $error("not free");
   quick_a: assert property (acc && req_cmd inside {tmc_pkg::CMD_MODE,
      tmc_pkg::CMD_RESERVE, tmc_pkg::CMD_RELEASE, tmc_pkg::CMD_SENSE}
      |=> rsp_valid) else $error("late answer");
   sense_a: assert property (acc && req_cmd == tmc_pkg::CMD_SENSE &&
      req_arg >= tmc_pkg::SENSE_BYTES |=> !ok) else $error("bad index taken");
   op_a: assert property (acc && req_cmd == tmc_pkg::CMD_REWIND |=>
      (rsp_valid && !ok) or (!rsp_valid [*4] ##1 rsp_valid))
      else $error("operation time");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench joining the channel end to the control unit end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic aclk = '0, aresetn = '0, communicator = '1, two_chan_sw = '1;
   logic cu_offline = '0, partition_en = '0, burst_seen = '0;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] cu_option = 2'h1, s_axi_bresp, s_axi_rresp;
   logic [15:0] partition_map = '0, drive_local = '1, drive_inuse = '0;
   logic [15:0] at_load_point = '1, nrzi_mode, rs = 16'h6248;
   logic [31:0] drive_option = 32'h5555_5555;
   int miscompares = 0, cmp_count = 0, n_rsp = 0;
   logic [33:0] exp_q[$], msk_q[$];
   always #4 aclk = ~aclk;
   tmc_link_if lnk (.aclk, .aresetn);
   tmc_chan i_tmc_chan (.lnk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   tmc_cu #(.EC_LEVEL(8'h5a)) i_tmc_cu (.lnk, .cu_option, .communicator,
      .two_chan_sw, .cu_offline, .partition_en, .partition_map, .drive_local,
      .drive_inuse, .at_load_point, .drive_option, .burst_seen,
      .id_burst_q(), .block_burst_q(), .xcu_access_q(), .op_active_q(),
      .reserved_q(), .res_chan_q(), .op_drive_q(), .nrzi_mode);
   tmc_link_checker i_chk (.aclk, .aresetn, .req_valid(lnk.req_valid),
      .req_ready(lnk.req_ready), .req_cmd(lnk.req_cmd),
      .req_arg(lnk.req_arg), .rsp_valid(lnk.rsp_valid),
      .rsp_ready(lnk.rsp_ready), .rsp_status(lnk.rsp_status));
   function automatic logic [15:0] xs(input logic [15:0] v);
      v ^= v << 7;
      v ^= v >> 9;
      v ^= v << 8;
      return v;
   endfunction
   task automatic cmp(input logic [33:0] v, e);
      cmp_count++;
      if (v !== e) begin
         miscompares++;
         $display("mismatch at %0t got %h expected %h", $time, v, e);
      end
   endtask
   task automatic summarize;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Notes are taken off in order as answers appear
   task automatic chk(input logic [33:0] v);
      logic [33:0] m;
      m = msk_q.pop_front();
      cmp(v & m, exp_q.pop_front() & m);
   endtask
   always @(posedge aclk) begin
      if (lnk.rsp_valid && lnk.rsp_ready) n_rsp++;
      if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata});
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, r);
      exp_q.push_back({32'h0, r[1:0]});
      msk_q.push_back('1);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= '1;
      s_axi_wvalid <= '1;
      s_axi_bready <= '1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= '0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= '0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      s_axi_araddr <= a;
      s_axi_arvalid <= '1;
      s_axi_rready <= '1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= '0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= '0;
   endtask
   // Flag bits 3 and 4 are masked: they may stay sticky
   task automatic op(input logic c, input logic [2:0] k, input logic [3:0] d,
         input logic [7:0] a, x, m, input logic [1:0] s);
      int n;
      n = n_rsp;
      wr(8'h00, {16'h0, a, d, k, c}, 32'h0);
      while (n_rsp == n) @(posedge aclk);
      repeat (2) @(posedge aclk);
      rd(8'h04, {18'h0, x, 5'h0, s, 1'h0}, {18'h3_ffff, m, 8'he7});
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      summarize;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= '1;
      repeat (3) @(posedge aclk);
      wr(8'h00, 32'h0000_0014, 32'h0);
      rd(8'h04, 34'h10, '1);
      rs = xs(rs);
      // Answer shows the drive mode as it stood when the command was taken
      op('0, 3'h1, 4'h1, {4'h0, rs[3:0]}, 8'h00, 8'hff, 2'h0);
      op('0, 3'h2, 4'h1, 8'h00, {4'h0, rs[3:0]}, 8'hff, 2'h0);
      op('0, 3'h7, 4'h1, 8'h00, 8'h00, 8'h00, 2'h0);
      burst_seen <= '1;
      op('0, 3'h3, 4'h2, 8'h00, 8'h00, 8'h01, 2'h0);
      burst_seen <= '0;
      op('0, 3'h3, 4'h3, 8'h00, 8'h00, 8'h01, 2'h0);
      op('0, 3'h7, 4'h3, 8'h00, 8'h01, 8'h01, 2'h0);
      cmp({18'h0, nrzi_mode}, {30'h2, rs[0], 1'h0});
      drive_option[9:8] <= 2'h0;
      op('0, 3'h3, 4'h4, 8'h00, 8'h00, 8'h00, 2'h2);
      op('0, 3'h4, 4'h0, 8'h00, 8'h00, 8'h00, 2'h0);
      op('1, 3'h6, 4'h0, 8'h0c, 8'h00, 8'h00, 2'h1);
      op('1, 3'h5, 4'h0, 8'h00, 8'h00, 8'h00, 2'h1);
      op('0, 3'h5, 4'h0, 8'h00, 8'h00, 8'h00, 2'h0);
      op('1, 3'h6, 4'h0, 8'h0c, 8'h5a, 8'hff, 2'h0);
      op('0, 3'h6, 4'h0, 8'h14, 8'h00, 8'h00, 2'h2);
      partition_en <= '1;
      op('1, 3'h3, 4'h3, 8'h00, 8'h00, 8'h00, 2'h2);
      two_chan_sw <= '0;
      op('1, 3'h6, 4'h0, 8'h00, 8'h00, 8'h00, 2'h2);
      cu_offline <= '1;
      op('0, 3'h6, 4'h0, 8'h00, 8'h00, 8'h00, 2'h3);
      wr(8'h40, 32'h0, 32'h2);
      rd(8'h40, {2'h2, 32'h0}, '1);
      summarize;
   end
endmodule
`default_nettype wire
